// ### iqm_top.sv
// Module: IQ mixer, gain/phase/offset correction, NCO and comparator clock divider behind APB
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// How it works
// - I and Q paths scaled by their own unsigned 11-bit gain, 0 to under 2.
// - Signed 10-bit skew cross-couples I and Q, range -1/8 to under +1/8.
// - Each path holds a signed 13-bit offset, -4096 to 4095.
// - Offset is added after the gain stage, just before the converter code.
// - 32-bit tuning word in four byte registers, 16-bit phase word in two.
// - Accumulator adds the tuning word every sample clock.
// - A sync event clears the phase accumulator to zero unless update code F0 is set.
// - Mixer rotates I/Q by accumulator phase plus phase word, scaled by boost.
// - Boost 0 gives about -6 dB, boost 1 about 0 dB and may clip.
// - Pin function 10 and update code F0 make sync load new words.
// - A sync-driven word update leaves the accumulator running.
// - New tuning word enters the accumulator six clocks after the sync.
// - Update code 00 loads the phase word when the low phase byte is written.
// - Comparator clock output is divided by 1, 2 or 4.
// - Sync pin is sampled on the data clock and initialises processing.
// - Sync pin acts only when pin function select is 10.
module iqm_top
    import iqm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire iqm_iq_s iq_in,
    input wire logic sync_pin,
    input wire logic cmp_in,
    output iqm_iq_s dac_out,
    output logic cmp_clk_out
);

    // Sine of a 6-bit angle by quadrant folding of the quarter table
    function automatic logic signed [15:0] sin6(input logic [5:0] ang);
        logic [3:0] idx;
        logic signed [15:0] mag;
        idx = ang[4] ? ~ang[3:0] : ang[3:0];
        mag = $signed(SIN_LUT[idx]);
        return ang[5] ? -mag : mag;
    endfunction : sin6

    // Mixer gain: full scale for boost, half for the -6 dB setting
    function automatic logic signed [15:0] mix_scale(input logic signed [30:0] full, input logic boost);
        logic signed [30:0] sh;
        sh = boost ? (full >>> LUT_FRAC) : (full >>> (LUT_FRAC + 1));
        return sh[15:0];
    endfunction : mix_scale

    // Unsigned gain with 10 fraction bits
    function automatic logic signed [17:0] gain_apply(input logic signed [15:0] x, input logic [10:0] g);
        logic signed [28:0] p;
        p = x * $signed({1'b0, g});
        return p[27:GAIN_FRAC];
    endfunction : gain_apply

    // Own path plus skewed other path plus offset
    function automatic logic signed [19:0] correct(input logic signed [17:0] own, input logic signed [17:0] other,
                                                   input logic signed [9:0] skew, input logic signed [12:0] ofs);
        logic signed [27:0] p;
        p = other * skew;
        return own + $signed(p[27:SKEW_FRAC]) + ofs;
    endfunction : correct

    // Clamp to the converter code range
    function automatic logic signed [13:0] sat14(input logic signed [19:0] v);
        if (v > DAC_MAX) begin
            return DAC_MAX;
        end else if (v < DAC_MIN) begin
            return DAC_MIN;
        end
        return v[13:0];
    endfunction : sat14

    logic [7:0] tune_byte [4];
    logic [7:0] phase_byte [2];
    logic [7:0] upd_code;
    logic [10:0] gain_i;
    logic [10:0] gain_q;
    logic [9:0] skew;
    logic [12:0] ofs_i;
    logic [12:0] ofs_q;
    logic [1:0] out_div;
    logic boost;
    logic [1:0] pin_sel;
    logic [31:0] freq_act;
    logic [31:0] freq_pend;
    logic [15:0] phase_act;
    logic [15:0] phase_pend;
    logic [31:0] acc;
    logic sync_prev;
    logic [SYNC_LATENCY-2:0] sync_pipe;
    logic signed [15:0] mix_i;
    logic signed [15:0] mix_q;
    logic signed [17:0] g_i;
    logic signed [17:0] g_q;
    logic cmp_prev;
    logic cmp_cnt;
    logic [31:0] next_rdata;
    logic next_miss;

    // APB phases; writes land only on the completing access edge
    wire setup = psel & ~penable;
    wire wr_acc = psel & penable & pready & pwrite;
    wire wr_tune0 = wr_acc && (paddr == REG_TUNE0);
    wire wr_phase0 = wr_acc && (paddr == REG_PHASE0);
    wire upd_write = (upd_code == UPD_WRITE);
    wire sync_armed = (pin_sel == PIN_SYNC);
    wire upd_sync_mode = sync_armed && (upd_code == UPD_SYNC);
    wire sync_edge = sync_pin & ~sync_prev;
    wire sync_ev = sync_edge & sync_armed;
    wire load_ev = sync_ev & upd_sync_mode;
    wire acc_clear = sync_ev & ~upd_sync_mode;
    wire load_now = sync_pipe[SYNC_LATENCY-2];

    // Register writes; the slave never waits, so pready is high from the first edge on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < 4; k++) begin
                tune_byte[k] <= BYTE_RST;
            end
            phase_byte[0] <= BYTE_RST;
            phase_byte[1] <= BYTE_RST;
            upd_code <= BYTE_RST;
            gain_i <= GAIN_RST;
            gain_q <= GAIN_RST;
            skew <= SKEW_RST;
            ofs_i <= OFS_RST;
            ofs_q <= OFS_RST;
            out_div <= DIV_RST;
            boost <= 1'b0;
            pin_sel <= PIN_RST;
        end else if (wr_acc) begin
            case (paddr)
                REG_TUNE0: tune_byte[0] <= pwdata[7:0];
                REG_TUNE1: tune_byte[1] <= pwdata[7:0];
                REG_TUNE2: tune_byte[2] <= pwdata[7:0];
                REG_TUNE3: tune_byte[3] <= pwdata[7:0];
                REG_PHASE0: phase_byte[0] <= pwdata[7:0];
                REG_PHASE1: phase_byte[1] <= pwdata[7:0];
                REG_UPDATE: upd_code <= pwdata[7:0];
                REG_GAIN_I: gain_i <= pwdata[10:0];
                REG_GAIN_Q: gain_q <= pwdata[10:0];
                REG_SKEW: skew <= pwdata[9:0];
                REG_OFS_I: ofs_i <= pwdata[12:0];
                REG_OFS_Q: ofs_q <= pwdata[12:0];
                REG_OUT_SETUP: begin
                    out_div <= pwdata[DIV_LSB +: 2];
                    boost <= pwdata[BOOST_BIT];
                end
                REG_PIN_FUNC: pin_sel <= pwdata[PIN_SEL_LSB +: 2];
                default: ;
            endcase
        end
    end

    // Read mux, evaluated in the setup cycle
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_miss = 1'b0;
        case (paddr)
            REG_TUNE0: next_rdata[7:0] = tune_byte[0];
            REG_TUNE1: next_rdata[7:0] = tune_byte[1];
            REG_TUNE2: next_rdata[7:0] = tune_byte[2];
            REG_TUNE3: next_rdata[7:0] = tune_byte[3];
            REG_PHASE0: next_rdata[7:0] = phase_byte[0];
            REG_PHASE1: next_rdata[7:0] = phase_byte[1];
            REG_UPDATE: next_rdata[7:0] = upd_code;
            REG_GAIN_I: next_rdata[10:0] = gain_i;
            REG_GAIN_Q: next_rdata[10:0] = gain_q;
            REG_SKEW: next_rdata[9:0] = skew;
            REG_OFS_I: next_rdata[12:0] = ofs_i;
            REG_OFS_Q: next_rdata[12:0] = ofs_q;
            REG_OUT_SETUP: next_rdata[2:0] = {boost, out_div};
            REG_PIN_FUNC: next_rdata[1:0] = pin_sel;
            REG_ACT_TUNE: next_rdata = freq_act;
            REG_ACT_PHASE: next_rdata[BUSY_BIT:0] = {|sync_pipe, phase_act};
            default: next_miss = 1'b1;
        endcase
    end

    // Answer registered at setup so data and error are ready in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= next_miss;
            end else if (!psel) begin
                pslverr <= 1'b0;
            end
        end
    end

    // Sync sampled on the same clock as the sample data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_prev <= 1'b0;
            sync_pipe <= '0;
        end else begin
            sync_prev <= sync_pin;
            sync_pipe <= {sync_pipe[SYNC_LATENCY-3:0], load_ev};
        end
    end

    // Pending words captured on the sync edge, applied at the end of the delay line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_pend <= 32'h0000_0000;
            phase_pend <= 16'h0000;
        end else if (load_ev) begin
            freq_pend <= {tune_byte[3], tune_byte[2], tune_byte[1], tune_byte[0]};
            phase_pend <= {phase_byte[1], phase_byte[0]};
        end
    end

    // Live oscillator words; a byte-0 write completes the word only if upper bytes went first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_act <= 32'h0000_0000;
            phase_act <= 16'h0000;
        end else begin
            if (load_now) begin
                freq_act <= freq_pend;
            end else if (wr_tune0 && upd_write) begin
                freq_act <= {tune_byte[3], tune_byte[2], tune_byte[1], pwdata[7:0]};
            end
            if (load_now) begin
                phase_act <= phase_pend;
            end else if (wr_phase0 && upd_write) begin
                phase_act <= {phase_byte[1], pwdata[7:0]};
            end
        end
    end

    // Phase accumulator; a word-update sync does not clear it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 32'h0000_0000;
        end else if (acc_clear) begin
            acc <= 32'h0000_0000;
        end else begin
            acc <= acc + freq_act;
        end
    end

    // Mixer; only 6 angle bits reach the table, so spurs sit near -36 dBc
    wire [15:0] angle = acc[31:16] + phase_act;
    wire signed [15:0] sn = sin6(angle[15:10]);
    wire signed [15:0] cs = sin6(angle[15:10] + 6'h10);
    wire signed [30:0] mix_i_full = iq_in.i * cs - iq_in.q * sn;
    wire signed [30:0] mix_q_full = iq_in.i * sn + iq_in.q * cs;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mix_i <= 16'sh0000;
            mix_q <= 16'sh0000;
        end else begin
            mix_i <= mix_scale(mix_i_full, boost);
            mix_q <= mix_scale(mix_q_full, boost);
        end
    end

    // Gain stage; headroom here lets the offset land without clipping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            g_i <= 18'sh00000;
            g_q <= 18'sh00000;
        end else begin
            g_i <= gain_apply(mix_i, gain_i);
            g_q <= gain_apply(mix_q, gain_q);
        end
    end

    // Skew and offset, then saturate into the converter code
    wire signed [19:0] sum_i = correct(g_i, g_q, $signed(skew), $signed(ofs_i));
    wire signed [19:0] sum_q = correct(g_q, g_i, $signed(skew), $signed(ofs_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_out <= '0;
        end else begin
            dac_out.i <= sat14(sum_i);
            dac_out.q <= sat14(sum_q);
        end
    end

    // Comparator divider; comparator can toggle as often as every pclk cycle and still be seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_prev <= 1'b0;
            cmp_cnt <= 1'b0;
            cmp_clk_out <= 1'b0;
        end else begin
            cmp_prev <= cmp_in;
            if (out_div == DIV_BY1) begin
                cmp_clk_out <= cmp_in;
            end else if (cmp_in && !cmp_prev) begin
                if (out_div == DIV_BY2 || cmp_cnt) begin
                    cmp_clk_out <= ~cmp_clk_out;
                end
                cmp_cnt <= ~cmp_cnt;
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_acc_step: assert property (!$past(acc_clear) |-> acc == $past(acc) + $past(freq_act))
        else $error("accumulator did not advance by the tuning word");
    a_acc_clear: assert property (acc_clear |=> acc == 32'h0000_0000)
        else $error("sync did not clear the accumulator");
    a_acc_keep: assert property (load_ev |=> acc == $past(acc) + $past(freq_act))
        else $error("word update sync disturbed the accumulator");
    a_sync_latency: assert property (load_ev |=> $stable(freq_act)[*5] ##1 (freq_act == $past(freq_pend)))
        else $error("tuning word not applied six clocks after sync");
    a_sync_gate: assert property (sync_edge && !sync_armed |=> acc == $past(acc) + $past(freq_act))
        else $error("sync acted with pin not in sync function");
    a_write_freq: assert property (wr_tune0 && upd_write && !load_now |=>
        freq_act == {$past(tune_byte[3]), $past(tune_byte[2]), $past(tune_byte[1]), $past(pwdata[7:0])})
        else $error("low tuning byte write did not load the word");
    a_write_phase: assert property (wr_phase0 && upd_write && !load_now |=>
        phase_act == {$past(phase_byte[1]), $past(pwdata[7:0])})
        else $error("low phase byte write did not load the word");
    a_no_write_load: assert property (wr_tune0 && !upd_write && !load_now |=> $stable(freq_act))
        else $error("tuning word loaded by write in sync mode");
    a_sat_high: assert property (sum_i > 20'sd8191 |=> dac_out.i == DAC_MAX)
        else $error("positive overflow not clamped");
    a_offset_pass: assert property (sum_q <= 20'sd8191 && sum_q >= -20'sd8192 |=> dac_out.q == $past(sum_q[13:0]))
        else $error("offset sum not passed to converter");
    a_div_one: assert property (out_div == DIV_BY1 |=> cmp_clk_out == $past(cmp_in))
        else $error("divide by one does not follow comparator");

    c_sync_load: cover property (load_ev ##6 load_now == 1'b0);
    c_sync_clear: cover property (acc_clear);
    c_clamp: cover property (sum_i > 20'sd8191);
    c_div_toggle: cover property (out_div != DIV_BY1 && $changed(cmp_clk_out));

endmodule : iqm_top

// ### iqm_pkg.sv
// Package: register map, field layout, constants and carriers of the IQ correction / NCO mixer path
package iqm_pkg;
    // Word-aligned byte offsets of the APB register file
    localparam logic [7:0] REG_TUNE0 = 8'h00;
    localparam logic [7:0] REG_TUNE1 = 8'h04;
    localparam logic [7:0] REG_TUNE2 = 8'h08;
    localparam logic [7:0] REG_TUNE3 = 8'h0C;
    localparam logic [7:0] REG_PHASE0 = 8'h10;
    localparam logic [7:0] REG_PHASE1 = 8'h14;
    localparam logic [7:0] REG_UPDATE = 8'h18;
    localparam logic [7:0] REG_GAIN_I = 8'h1C;
    localparam logic [7:0] REG_GAIN_Q = 8'h20;
    localparam logic [7:0] REG_SKEW = 8'h24;
    localparam logic [7:0] REG_OFS_I = 8'h28;
    localparam logic [7:0] REG_OFS_Q = 8'h2C;
    localparam logic [7:0] REG_OUT_SETUP = 8'h30;
    localparam logic [7:0] REG_PIN_FUNC = 8'h34;
    localparam logic [7:0] REG_ACT_TUNE = 8'h38;
    localparam logic [7:0] REG_ACT_PHASE = 8'h3C;
    // Field positions
    localparam int DIV_LSB = 0;
    localparam int BOOST_BIT = 2;
    localparam int PIN_SEL_LSB = 0;
    localparam int BUSY_BIT = 16;
    // Reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [10:0] GAIN_RST = 11'h400;
    localparam logic [9:0] SKEW_RST = 10'h000;
    localparam logic [12:0] OFS_RST = 13'h0000;
    localparam logic [1:0] DIV_RST = 2'h0;
    localparam logic [1:0] PIN_RST = 2'h0;
    // Codes
    localparam logic [7:0] UPD_WRITE = 8'h00;
    localparam logic [7:0] UPD_SYNC = 8'hF0;
    localparam logic [1:0] PIN_SYNC = 2'h2;
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    // Arithmetic scaling
    localparam int GAIN_FRAC = 10;
    localparam int SKEW_FRAC = 12;
    localparam int LUT_FRAC = 14;
    localparam logic signed [13:0] DAC_MAX = 14'sh1FFF;
    localparam logic signed [13:0] DAC_MIN = -14'sh2000;
    // Sync to new tuning word, in sample clocks
    localparam int SYNC_LATENCY = 6;
    // Quarter-wave sine, 16 points at half-step offsets, amplitude 2^14
    localparam logic [15:0] SIN_LUT [16] = '{16'h0324, 16'h0964, 16'h0F8D, 16'h1590, 16'h1B5D, 16'h20E7,
        16'h2620, 16'h2AFB, 16'h2F6C, 16'h3368, 16'h36E5, 16'h39DB, 16'h3C42, 16'h3E15, 16'h3F4F, 16'h3FEC};
    typedef struct packed {
        logic signed [13:0] i;
        logic signed [13:0] q;
    } iqm_iq_s;
endpackage : iqm_pkg

// ### iqm_src.sv
// Upstream sample source and sync pulser feeding the IQ mixer path
`timescale 1ns/100ps
module iqm_src
    import iqm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire iqm_iq_s smp,
    input wire logic fire,
    output iqm_iq_s iq_in,
    output logic sync_pin
);
    // Samples and sync leave on the data clock, so sync is seen like data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iq_in <= '0;
            sync_pin <= 1'b0;
        end else begin
            iq_in <= smp;
            sync_pin <= fire;
        end
    end
endmodule : iqm_src

// ### tb.sv
// Testbench: registers, NCO word updates, data path and clock divider
`timescale 1ns/100ps
module tb;
    import iqm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0, cmp_in = 1'b0, cmp_run = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h45, t, u, v, w;
    logic pready, pslverr, sync_pin, cmp_clk_out;
    iqm_iq_s iq_in, dac_out, smp = '0;
    logic [32:0] exp_q [$];
    int miscompares = 0, cmp_count = 0, cycles = 0, k;
    iqm_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .iq_in(iq_in), .sync_pin(sync_pin), .cmp_in(cmp_in), .dac_out(dac_out), .cmp_clk_out(cmp_clk_out));
    iqm_src SRC (.pclk(pclk), .presetn(presetn), .smp(smp), .fire(fire), .iq_in(iq_in), .sync_pin(sync_pin));
    // Bench clock, 25 ns
    initial forever #12.5 pclk = ~pclk;
    // Comparator toggles each cycle while the divider is under test
    always @(posedge pclk) cmp_in <= cmp_run & ~cmp_in;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    function automatic logic [13:0] cl(input int x);
        return (x > 8191) ? DAC_MAX : (x < -8192) ? DAC_MIN : 14'(x);
    endfunction : cl
    // Path model at zero angle: mixer, gain, skew, offset, clamp
    function automatic logic [27:0] model(input int i, input int q, input int sh, input int g, input int s,
        input int o);
        int lo, hi, mi, mq;
        lo = int'(SIN_LUT[0]);
        hi = int'(SIN_LUT[15]);
        mi = (((i * hi - q * lo) >>> sh) * g) >>> GAIN_FRAC;
        mq = (((i * lo + q * hi) >>> sh) * g) >>> GAIN_FRAC;
        return {cl(mi + ((mq * s) >>> SKEW_FRAC) + o), cl(mq + ((mi * s) >>> SKEW_FRAC) - o - 1)};
    endfunction : model
    task automatic chk(input logic [32:0] got, input logic [32:0] want);
        cmp_count++;
        if (got !== want) begin
            miscompares++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : chk
    task automatic conclude();
        // A read that never completed leaves its note behind
        if (exp_q.size() != 0) miscompares++;
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_n;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit: only the hang guard may end a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] want);
        exp_q.push_back(want);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // Oldest note against each completed read
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) chk({pslverr, prdata}, exp_q.pop_front());
    end
    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic pulse();
        @(posedge pclk);
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
    endtask : pulse
    task automatic dp(input int i, input int q, input logic b, input int g, input int s, input int o);
        smp <= {14'(i), 14'(q)};
        wr(REG_OUT_SETUP, {29'h0, b, 2'h0});
        wr(REG_GAIN_I, 32'(g));
        wr(REG_GAIN_Q, 32'(g));
        wr(REG_SKEW, 32'(s) & 32'h3FF);
        wr(REG_OFS_I, 32'(o) & 32'h1FFF);
        wr(REG_OFS_Q, 32'(-o - 1) & 32'h1FFF);
        repeat (6) @(negedge pclk);
        chk({5'h0, dac_out}, {5'h0, model(i, q, b ? 14 : 15, g, s, o)});
    endtask : dp
    // Toggles of the divided output over 64 cycles
    task automatic divchk(input logic [1:0] dv, input int want);
        int n;
        logic p;
        wr(REG_OUT_SETUP, {30'h0, dv});
        repeat (8) @(negedge pclk);
        n = 0;
        p = cmp_clk_out;
        repeat (64) begin
            @(negedge pclk);
            if (cmp_clk_out !== p) n++;
            p = cmp_clk_out;
        end
        chk(33'(n), 33'(want));
    endtask : divchk
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then unmapped and unaligned places
        for (k = 0; k < 16; k++) rd(8'(4 * k), {1'b0, (k == 7 || k == 8) ? {21'h0, GAIN_RST} : 32'h0});
        rd(8'h40, {1'b1, 32'h0});
        rd(8'h01, {1'b1, 32'h0});
        // Write-triggered loads, upper bytes first
        t = rnd();
        u = rnd();
        for (k = 3; k > 0; k--) wr(8'(4 * k), {24'h0, t[8 * k +: 8]});
        wr(REG_PHASE1, {24'h0, u[15:8]});
        rd(REG_ACT_TUNE, {1'b0, 32'h0});
        rd(REG_ACT_PHASE, {1'b0, 32'h0});
        wr(REG_TUNE0, {24'h0, t[7:0]});
        wr(REG_PHASE0, {24'h0, u[7:0]});
        rd(REG_ACT_TUNE, {1'b0, t});
        rd(REG_ACT_PHASE, {17'h0, u[15:0]});
        // Sync-triggered loads; pin ignored unless its function is sync
        v = rnd();
        w = rnd();
        wr(REG_UPDATE, {24'h0, UPD_SYNC});
        for (k = 3; k >= 0; k--) wr(8'(4 * k), {24'h0, v[8 * k +: 8]});
        wr(REG_PHASE1, {24'h0, w[15:8]});
        wr(REG_PHASE0, {24'h0, w[7:0]});
        pulse();
        repeat (10) @(posedge pclk);
        rd(REG_ACT_TUNE, {1'b0, t});
        wr(REG_PIN_FUNC, {30'h0, PIN_SYNC});
        pulse();
        rd(REG_ACT_PHASE, {16'h0, 1'b1, u[15:0]});
        repeat (8) @(posedge pclk);
        rd(REG_ACT_TUNE, {1'b0, v});
        rd(REG_ACT_PHASE, {17'h0, w[15:0]});
        // Zero words, then sync outside sync-load mode clears the accumulator
        wr(REG_UPDATE, {24'h0, UPD_WRITE});
        for (k = 3; k >= 0; k--) wr(8'(4 * k), 32'h0);
        wr(REG_PHASE1, 32'h0);
        wr(REG_PHASE0, 32'h0);
        // Unknown update code: a byte-0 write must not reach the oscillator
        wr(REG_UPDATE, 32'h0000_0055);
        wr(REG_TUNE0, 32'h0000_00AA);
        rd(REG_ACT_TUNE, {1'b0, 32'h0});
        pulse();
        dp(4096, 0, 1'b1, 1024, 0, 0);
        dp(4096, 0, 1'b0, 1024, 0, 0);
        t = rnd();
        dp(int'($signed(t[11:0])), int'($signed(t[27:16])), 1'b1, 0, 0, int'($signed(t[12:0])));
        t = rnd();
        dp(int'($signed(t[11:0])), int'($signed(t[23:12])), 1'b1, 1024 + t[8:0], 511, 300);
        t = rnd();
        dp(int'($signed(t[11:0])), int'($signed(t[23:12])), 1'b0, 1448, -512, -700);
        dp(8191, 0, 1'b1, 2047, 0, 4095);
        dp(-8192, 0, 1'b1, 2047, 0, -4096);
        // Divider settings, value 3 acting as the largest ratio
        cmp_run <= 1'b1;
        for (k = 0; k < 4; k++) divchk(2'(k), (k == 0) ? 64 : (k == 1) ? 32 : 16);
        conclude();
    end
endmodule : tb
